// [hw/ioo_decode_defs.vh]
// Purpose: constants for the indexed offset operand decoder
// Assumes: 12-bit data address space, 16-bit opcodes
// Notes: included by both design files
`ifndef IOO_DECODE_DEFS_VH
`define IOO_DECODE_DEFS_VH
`define IOO_ADDR_W 12
`define IOO_OFFSET_MAX 8'h5F
`define IOO_ACCESS_SPLIT 8'h60
`define IOO_ACCESS_HIGH_BANK 4'hF
`define IOO_ZERO_BANK 4'h0
`define IOO_ADDR_RST 12'h000
`define IOO_BYTE_RST 8'h00
`define IOO_ALL_ONES 8'hFF
`define IOO_OP_ADD_IX 6'h09
`define IOO_OP_SET_ALL_IX 8'h68
`define IOO_OP_BIT_SET_IX 4'h8
`define IOO_F_ACCESS 8
`define IOO_F_DEST 9
`define IOO_F_FILE_HI 7
`define IOO_F_FILE_LO 0
`define IOO_F_OP_HI 15
`define IOO_F_ADD_LO 10
`define IOO_F_BSET_LO 12
`define IOO_F_SETALL_LO 8
`define IOO_F_BIT_HI 11
`define IOO_F_BIT_LO 9
`define IOO_FLAGS_RST 5'h00
`define IOO_BIT_ONE 8'h01
`define IOO_BYTE_HI 7
`define IOO_NIBBLE_HI 3
`define IOO_NIBBLE_CARRY 4
`define IOO_SIGN 7
`define IOO_CARRY 8
`define IOO_KIND_NONE 2'h0
`define IOO_KIND_ADD 2'h1
`define IOO_KIND_BSET 2'h2
`define IOO_KIND_SETALL 2'h3
`define IOO_FLAG_N 4
`define IOO_FLAG_OV 3
`define IOO_FLAG_Z 2
`define IOO_FLAG_DC 1
`define IOO_FLAG_C 0
`endif

// [hw/ioo_addr_calc.v]
// Purpose: combinational effective address for one file operand
// Assumes: pointer and bank inputs are stable within the cycle
// Notes: no state; main decoder registers the result
`timescale 1ns/1ps
`include "ioo_decode_defs.vh"
module ioo_addr_calc (
   input wire [7:0] fileField,
   input wire accessBit,
   input wire extendedSetEnable,
   input wire [11:0] indirectPointerTwo,
   input wire [3:0] bankSelectRegister,
   output reg [11:0] effAddr,
   output reg indexed
);
   function [11:0] accessBankAddr;
      input [7:0] f;
      begin
         if (f < `IOO_ACCESS_SPLIT) begin
            accessBankAddr = {`IOO_ZERO_BANK, f};
         end else begin
            accessBankAddr = {`IOO_ACCESS_HIGH_BANK, f};
         end
      end
   endfunction

   always @* begin
      indexed = extendedSetEnable && !accessBit && (fileField <= `IOO_OFFSET_MAX);
      if (accessBit) begin
         effAddr = {bankSelectRegister, fileField};
      end else if (indexed) begin
         // Wraps at the address width; pointer is never modified here
         effAddr = indirectPointerTwo + {`IOO_ZERO_BANK, fileField};
      end else begin
         effAddr = accessBankAddr(fileField);
      end
   end
endmodule

// [hw/ioo_operand_decode.v]
// Purpose: operand address decode and indexed forms of add, bit set and set all
// Assumes: one instruction per enabled cycle, memory read data valid with the opcode
// Notes: results registered; one cycle latency from opcode to outputs
// Contract
// - With the extension off the file field is a literal access-bank or banked location.
// - With the extension on and access bit 0, fields up to 5Fh are offsets added to pointer two.
// - Fields above 5Fh with access bit 0 keep their access-bank meaning.
// - Every byte and bit instruction with the access bit set uses the banked interpretation, never the indexed one.
// - A zero pointer makes indexed accesses hit the ordinary access-bank low locations.
// - One configuration bit enables both extended instructions and indexed addressing.
// - Pattern 0010 01d0 kkkk kkkk adds the working register to the byte at pointer plus offset.
// - The indexed add updates negative, overflow, carry, digit carry and zero.
// - The add result goes to the working register when d is 0, else back to memory.
// - Pattern 1000 bbb0 kkkk kkkk sets bit b of the indexed byte without touching flags.
// - Pattern 0110 1000 kkkk kkkk writes FFh to the indexed byte without touching flags.
`timescale 1ns/1ps
`include "ioo_decode_defs.vh"
module ioo_operand_decode (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire opValid,
   input wire [15:0] opcode,
   input wire extendedSetEnable,
   input wire [11:0] indirectPointerTwo,
   input wire [3:0] bankSelectRegister,
   input wire [7:0] workingReg,
   input wire [7:0] memReadData,
   output reg [11:0] dataAddr,
   output reg indexedAccess,
   output reg destToFile,
   output reg [1:0] opKind,
   output reg [7:0] resultData,
   output reg writeWorking,
   output reg writeMem,
   output reg [4:0] flagsOut,
   output reg flagsUpdate
);
   localparam KIND_NONE = `IOO_KIND_NONE;
   localparam KIND_ADD = `IOO_KIND_ADD;
   localparam KIND_BSET = `IOO_KIND_BSET;
   localparam KIND_SETALL = `IOO_KIND_SETALL;

   wire accessBit = opcode[`IOO_F_ACCESS];
   wire destBit = opcode[`IOO_F_DEST];
   wire [7:0] fileField = opcode[`IOO_F_FILE_HI:`IOO_F_FILE_LO];
   wire [2:0] bitSelect = opcode[`IOO_F_BIT_HI:`IOO_F_BIT_LO];
   wire [5:0] addGroup = opcode[`IOO_F_OP_HI:`IOO_F_ADD_LO];
   wire [3:0] bitSetGroup = opcode[`IOO_F_OP_HI:`IOO_F_BSET_LO];
   wire [7:0] setAllGroup = opcode[`IOO_F_OP_HI:`IOO_F_SETALL_LO];
   wire [11:0] calcAddr;
   wire calcIndexed;
   wire isAdd;
   wire isBitSet;
   wire isSetAll;

   // Access bit sits at bit 8 for every byte and bit format, so one calculator serves all
   ioo_addr_calc ioo_addr_calc_inst (
      .fileField(fileField),
      .accessBit(accessBit),
      .extendedSetEnable(extendedSetEnable),
      .indirectPointerTwo(indirectPointerTwo),
      .bankSelectRegister(bankSelectRegister),
      .effAddr(calcAddr),
      .indexed(calcIndexed)
   );

   // Nine-bit sum keeps the carry out for the flag logic
   function [8:0] byteSum;
      input [7:0] x;
      input [7:0] y;
      begin
         byteSum = {1'b0, x} + {1'b0, y};
      end
   endfunction

   function [4:0] nibbleSum;
      input [3:0] x;
      input [3:0] y;
      begin
         nibbleSum = {1'b0, x} + {1'b0, y};
      end
   endfunction

   function [4:0] addFlags;
      input [7:0] x;
      input [7:0] y;
      reg [8:0] s;
      reg [4:0] h;
      begin
         s = byteSum(x, y);
         h = nibbleSum(x[`IOO_NIBBLE_HI:0], y[`IOO_NIBBLE_HI:0]);
         addFlags = `IOO_FLAGS_RST;
         addFlags[`IOO_FLAG_C] = s[`IOO_CARRY];
         addFlags[`IOO_FLAG_DC] = h[`IOO_NIBBLE_CARRY];
         addFlags[`IOO_FLAG_Z] = (s[`IOO_BYTE_HI:0] == `IOO_BYTE_RST);
         addFlags[`IOO_FLAG_N] = s[`IOO_SIGN];
         addFlags[`IOO_FLAG_OV] = (x[`IOO_SIGN] == y[`IOO_SIGN]) && (s[`IOO_SIGN] != x[`IOO_SIGN]);
      end
   endfunction

   function [7:0] bitMask;
      input [2:0] sel;
      begin
         bitMask = `IOO_BIT_ONE << sel;
      end
   endfunction

   reg [1:0] next_kind;
   reg [7:0] next_result;
   reg [4:0] next_flags;
   reg next_writeWorking;
   reg next_writeMem;
   reg next_flagsUpdate;
   wire [8:0] addSum = byteSum(workingReg, memReadData);

   // Only offset-qualified fields reach these forms; above 5Fh the ordinary op runs elsewhere
   assign isAdd = calcIndexed && (addGroup == `IOO_OP_ADD_IX);
   assign isBitSet = calcIndexed && !isAdd && (bitSetGroup == `IOO_OP_BIT_SET_IX);
   assign isSetAll = calcIndexed && !isAdd && !isBitSet && (setAllGroup == `IOO_OP_SET_ALL_IX);

   always @* begin
      next_kind = KIND_NONE;
      if (opValid) begin
         if (isAdd) begin
            next_kind = KIND_ADD;
         end else if (isBitSet) begin
            next_kind = KIND_BSET;
         end else if (isSetAll) begin
            next_kind = KIND_SETALL;
         end
      end
   end

   always @* begin
      next_result = `IOO_BYTE_RST;
      if (isAdd) begin
         next_result = addSum[`IOO_BYTE_HI:0];
      end else if (isBitSet) begin
         next_result = memReadData | bitMask(bitSelect);
      end else if (isSetAll) begin
         next_result = `IOO_ALL_ONES;
      end
   end

   always @* begin
      next_flags = `IOO_FLAGS_RST;
      if (isAdd) begin
         next_flags = addFlags(workingReg, memReadData);
      end
   end

   // Bit set and set all leave the flags alone, so only the add raises the flag strobe
   always @* begin
      next_writeWorking = 1'b0;
      next_writeMem = 1'b0;
      next_flagsUpdate = 1'b0;
      case (next_kind)
         KIND_ADD: begin
            next_writeWorking = !destBit;
            next_writeMem = destBit;
            next_flagsUpdate = 1'b1;
         end
         KIND_BSET: begin
            next_writeMem = 1'b1;
         end
         KIND_SETALL: begin
            next_writeMem = 1'b1;
         end
         default: begin
            next_writeMem = 1'b0;
         end
      endcase
   end

   // Reset does not wait for ce, so a stalled core still comes up clean
   always @(posedge clk) begin
      if (rst) begin
         dataAddr <= `IOO_ADDR_RST;
         indexedAccess <= 1'b0;
         destToFile <= 1'b0;
      end else if (ce) begin
         dataAddr <= calcAddr;
         indexedAccess <= opValid && calcIndexed;
         destToFile <= destBit;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         opKind <= KIND_NONE;
         resultData <= `IOO_BYTE_RST;
         flagsOut <= `IOO_FLAGS_RST;
      end else if (ce) begin
         opKind <= next_kind;
         resultData <= next_result;
         flagsOut <= next_flags;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         writeWorking <= 1'b0;
         writeMem <= 1'b0;
         flagsUpdate <= 1'b0;
      end else if (ce) begin
         writeWorking <= next_writeWorking;
         writeMem <= next_writeMem;
         flagsUpdate <= next_flagsUpdate;
      end
   end
endmodule

// [tb/ioo_decode_props.sv]
// Purpose: port assertions for the operand decoder
// Assumes: outputs follow the taking edge by one cycle
// Notes: only carry is checked among the add flags
`timescale 1ns/1ps
module ioo_decode_props (input logic clk, rst, ce, opValid, extendedSetEnable, writeWorking, writeMem,
   input logic flagsUpdate, input logic [15:0] opcode, input logic [11:0] indirectPointerTwo, dataAddr,
   input logic [3:0] bankSelectRegister, input logic [7:0] workingReg, memReadData, resultData,
   input logic indexedAccess, input logic [1:0] opKind, input logic [4:0] flagsOut);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic live = 1'b0;
   wire ix = extendedSetEnable && !opcode[8] && opcode[7:0] <= 8'h5F;
   wire go = opValid && ix;
   wire [8:0] sum = workingReg + memReadData;
   // A frozen cycle must not be judged against fresh inputs
   always @(posedge clk) live <= ce && !rst;
   a_banked_addr: assert property (live && $past(opcode[8]) |->
      dataAddr == {$past(bankSelectRegister), $past(opcode[7:0])}) else $error("bad banked address");
   a_indexed_addr: assert property (live && $past(ix) |->
      dataAddr == $past(indirectPointerTwo + opcode[7:0])) else $error("bad indexed address");
   a_access_addr: assert property (live && $past(!opcode[8] && !ix) |->
      dataAddr == {{4{$past(opcode[7:0] > 8'h5F)}}, $past(opcode[7:0])}) else $error("bad access address");
   a_indexed_flag: assert property (live |-> indexedAccess == $past(go))
      else $error("bad indexed flag");
   a_add_result: assert property (live && $past(go && opcode[15:10] == 6'h09) |->
      opKind == 2'h1 && resultData == $past(sum[7:0]) && flagsOut[0] == $past(sum[8]) && flagsUpdate
      && writeMem == $past(opcode[9]) && writeWorking != writeMem) else $error("bad add");
   a_bit_set: assert property (live && $past(go && opcode[15:12] == 4'h8) |-> opKind == 2'h2 &&
      resultData == ($past(memReadData) | 8'h01 << $past(opcode[11:9])) && writeMem && !flagsUpdate)
      else $error("bad bit set");
   a_set_all: assert property (live && $past(go && opcode[15:8] == 8'h68) |->
      ##0 opKind == 2'h3 && resultData == 8'hFF && writeMem && !flagsUpdate) else $error("bad set all");
   a_plain_quiet: assert property (live && !$past(go) |->
      opKind == 2'h0 && !writeMem && !writeWorking && !flagsUpdate) else $error("strobe on plain op");
endmodule

// [tb/ioo_operand_decode_bench.sv]
// Purpose: directed bench for the operand decoder
// Assumes: ce and opValid high except in the quiet test
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module ioo_operand_decode_bench;
   reg clk = 1'b0, rst = 1'b1, ce = 1'b1, opValid = 1'b1, extendedSetEnable = 1'b0;
   reg [15:0] opcode = 16'h0000;
   reg [11:0] indirectPointerTwo = 12'hA00;
   reg [3:0] bankSelectRegister = 4'h5;
   reg [7:0] workingReg = 8'h17, memReadData = 8'h00;
   wire [11:0] dataAddr;
   wire indexedAccess, destToFile, writeWorking, writeMem, flagsUpdate;
   wire [1:0] opKind;
   wire [7:0] resultData;
   wire [4:0] flagsOut;
   integer err_count = 0, check_count = 0, b;
   always #2 clk = ~clk;
   ioo_operand_decode ioo_operand_decode_inst (.*);
   task chk(input [15:0] seen, exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   // Expected word packs address, kind, memory and working strobes
   task run(input [15:0] o, input [7:0] m, input [15:0] e, input [7:0] r);
      begin
         opcode = o;
         memReadData = m;
         @(posedge clk);
         #1;
         chk({dataAddr, opKind, writeMem, writeWorking}, e);
         if (e[3:2] != 2'h0) chk(resultData, r);
         chk(destToFile, o[9]);
      end
   endtask
   task t_legacy;
      begin
         run(16'h2420, 8'h00, 16'h0200, 8'h00);
         run(16'h2520, 8'h00, 16'h5200, 8'h00);
         run(16'h24E0, 8'h00, 16'hFE00, 8'h00);
         $display("legacy done");
      end
   endtask
   task t_indexed;
      begin
         extendedSetEnable = 1'b1;
         run(16'h242C, 8'h20, 16'hA2C5, 8'h37);
         chk(indexedAccess, 16'h0001);
         run(16'h262C, 8'h20, 16'hA2C6, 8'h37);
         run(16'h2460, 8'h00, 16'hF600, 8'h00);
         run(16'h682C, 8'h00, 16'hA2CE, 8'hFF);
         for (b = 0; b < 8; b = b + 1)
            run({4'h8, b[2:0], 9'h00A}, 8'h55, 16'hA0AA, 8'h55 | 8'h01 << b[2:0]);
         $display("indexed done");
      end
   endtask
   task t_edges;
      begin
         run(16'h245F, 8'h00, 16'hA5F5, 8'h17);
         indirectPointerTwo = 12'h000;
         run(16'h2410, 8'h00, 16'h0105, 8'h17);
         indirectPointerTwo = 12'hFFF;
         run(16'h245F, 8'h00, 16'h05E5, 8'h17);
         workingReg = 8'h80;
         run(16'h2400, 8'h80, 16'hFFF5, 8'h00);
         chk({flagsUpdate, flagsOut}, 16'h002D);
         $display("edges done");
      end
   endtask
   task t_quiet;
      begin
         ce = 1'b0;
         opcode = 16'h682C;
         @(posedge clk);
         #1;
         chk({dataAddr, opKind, writeMem, writeWorking}, 16'hFFF5);
         ce = 1'b1;
         opValid = 1'b0;
         indirectPointerTwo = 12'hA00;
         run(16'h682C, 8'h00, 16'hA2C0, 8'h00);
         chk(indexedAccess, 16'h0000);
         opValid = 1'b1;
         rst = 1'b1;
         @(posedge clk);
         #1;
         rst = 1'b0;
         chk({dataAddr, opKind, writeMem, writeWorking}, 16'h0000);
         chk({flagsUpdate, flagsOut}, 16'h0000);
         run(16'h682C, 8'h00, 16'hA2CE, 8'hFF);
         $display("quiet done");
      end
   endtask
   task conclude;
      begin
         $display("checks=%0d mismatches=%0d", check_count, err_count);
         if (err_count == 0 && check_count > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      t_legacy;
      t_indexed;
      t_edges;
      t_quiet;
      conclude;
   end
   initial begin
      #2000;
      err_count = err_count + 1;
      conclude;
   end
endmodule
bind ioo_operand_decode ioo_decode_props ioo_decode_props_inst (.*);
